// ==== core/timer_pkg.sv ====
package timer_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] BASIC_MODE_OFS  = 8'hD8;
  localparam logic [7:0] BASIC_COUNT_OFS = 8'hD9;
  localparam logic [7:0] EVENT_MODE_OFS  = 8'hDA;
  localparam logic [7:0] EVENT_COUNT_OFS = 8'hDB;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'hDC;
  localparam logic [7:0] IRQ_ENABLE_OFS  = 8'hDD;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int RUN_BIT        = 7;
  localparam int RATE_LSB       = 4;
  localparam int SRC_BIT        = 3;
  localparam int BASIC_IRQ_BIT  = 0;
  localparam int EVENT_IRQ_BIT  = 1;
  localparam int PIN_IRQ_BIT    = 2;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [2:0] IRQ_RESET    = 3'h0;
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] DIV_ALL_ONES = 8'hFF;
  localparam logic [3:0] DIV_STAGES   = 4'h8;
  localparam logic       PIN_IDLE     = 1'b1;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic       run;
    logic [2:0] rate;
    logic       src;
    logic [2:0] unused;
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic basic_mode;
    logic basic_count;
    logic event_mode;
    logic event_count;
    logic irq_status;
    logic irq_enable;
  } reg_sel_t;

endpackage : timer_pkg

// ==== core/rate_divider.sv ====
`timescale 1ns/100ps

// ************************************************************
// Divides ref_clk by 2 to the power (8 - rate)
// ************************************************************
module rate_divider (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic [2:0] rate,
  output      logic       tick
);

  logic [7:0] div_reg;
  logic [3:0] shift;
  logic [7:0] mask;

  // Cleared while idle so the first step after enabling is a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= timer_pkg::COUNT_RESET;
    end else if (clear) begin
      div_reg <= timer_pkg::COUNT_RESET;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_comb begin
    shift = timer_pkg::DIV_STAGES - {1'b0, rate};
    mask  = timer_pkg::DIV_ALL_ONES << shift;
    tick  = !clear && ((div_reg | mask) == timer_pkg::DIV_ALL_ONES);
  end

endmodule : rate_divider

// ==== core/count_unit.sv ====
`timescale 1ns/100ps

// ************************************************************
// 8-bit up counter with load and wrap report
// ************************************************************
module count_unit (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic       step,
  output      logic [7:0] count,
  output      logic       wrap
);

  logic [7:0] count_reg;

  // A load replaces the count even on a step cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= timer_pkg::COUNT_RESET;
    end else if (load) begin
      count_reg <= load_value;
    end else if (step) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  always_comb begin
    count = count_reg;
    wrap  = step && !load && (count_reg == timer_pkg::COUNT_MAX);
  end

endmodule : count_unit

// ==== core/dual_eight_bit_timers.sv ====
// Function
// - Basic timer counts up 8 bits, keeps counting past wrap, sets flag.
// - Basic mode bit 7 zero stops the basic timer, one runs it.
// - Basic mode bits 6:4 pick divide by 256 down to 2.
// - Basic count is 8-bit read/write, zero at reset; software preloads.
// - Event timer counts up 8 bits from internal clock or pin.
// - In external mode each pin falling edge adds one.
// - Event mode bit 3 picks internal prescaler zero or pin one.
// - External mode ignores prescale and holds pin flag at zero.
// - Event timer keeps counting past wrap and sets its flag.
// - Event mode bit 7 zero stops the event timer, one runs it.
// - Event mode bits 6:4 pick divide by 256 down to 2.
// - Event count is 8-bit read/write, zero at reset; software preloads.
`timescale 1ns/100ps

module dual_eight_bit_timers (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output      logic [7:0] bus_rdata,
  input  wire logic       event_input_pin,
  output      logic       irq
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  function automatic timer_pkg::reg_sel_t decode(input logic [7:0] addr);
    timer_pkg::reg_sel_t sel;
    sel             = '0;
    sel.basic_mode  = (addr == timer_pkg::BASIC_MODE_OFS);
    sel.basic_count = (addr == timer_pkg::BASIC_COUNT_OFS);
    sel.event_mode  = (addr == timer_pkg::EVENT_MODE_OFS);
    sel.event_count = (addr == timer_pkg::EVENT_COUNT_OFS);
    sel.irq_status  = (addr == timer_pkg::IRQ_STATUS_OFS);
    sel.irq_enable  = (addr == timer_pkg::IRQ_ENABLE_OFS);
    return sel;
  endfunction : decode

  timer_pkg::bus_req_t req;
  timer_pkg::reg_sel_t wr_sel;
  timer_pkg::reg_sel_t rd_sel;

  always_comb begin
    req.addr  = bus_addr;
    req.wdata = bus_wdata;
    req.wr    = bus_wr;
    req.rd    = bus_rd;
    wr_sel    = req.wr ? decode(req.addr) : '0;
    rd_sel    = req.rd ? decode(req.addr) : '0;
  end

  // ************************************************************
  // Mode registers
  // ************************************************************
  timer_pkg::mode_t basic_mode_reg;
  timer_pkg::mode_t event_mode_reg;

  // Only documented bits are stored; the rest always read as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      basic_mode_reg <= timer_pkg::MODE_RESET;
    end else if (wr_sel.basic_mode) begin
      basic_mode_reg.run    <= req.wdata[timer_pkg::RUN_BIT];
      basic_mode_reg.rate   <= req.wdata[timer_pkg::RATE_LSB +: 3];
      basic_mode_reg.src    <= 1'b0;
      basic_mode_reg.unused <= 3'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_mode_reg <= timer_pkg::MODE_RESET;
    end else if (wr_sel.event_mode) begin
      event_mode_reg.run    <= req.wdata[timer_pkg::RUN_BIT];
      event_mode_reg.rate   <= req.wdata[timer_pkg::RATE_LSB +: 3];
      event_mode_reg.src    <= req.wdata[timer_pkg::SRC_BIT];
      event_mode_reg.unused <= 3'h0;
    end
  end

  // ************************************************************
  // Event pin edge detection
  // ************************************************************
  logic pin_reg;
  logic pin_prev_reg;
  logic pin_fall;

  // Idle level is high so leaving reset with the pin high never fakes a falling edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg      <= timer_pkg::PIN_IDLE;
      pin_prev_reg <= timer_pkg::PIN_IDLE;
    end else begin
      pin_reg      <= event_input_pin;
      pin_prev_reg <= pin_reg;
    end
  end

  assign pin_fall = pin_prev_reg && !pin_reg;

  // ************************************************************
  // Count clocks and counters
  // ************************************************************
  logic       run       [2];
  logic [2:0] rate      [2];
  logic       div_clear [2];
  logic       div_tick  [2];
  logic       step      [2];
  logic       load      [2];
  logic [7:0] count     [2];
  logic       wrap      [2];
  logic       event_ext;

  assign event_ext = event_mode_reg.src;

  always_comb begin
    run[0]       = basic_mode_reg.run;
    run[1]       = event_mode_reg.run;
    rate[0]      = basic_mode_reg.rate;
    rate[1]      = event_mode_reg.rate;
    // Prescaler is idle and ignored while the pin drives the count
    div_clear[0] = !run[0];
    div_clear[1] = !run[1] || event_ext;
    step[0]      = run[0] && div_tick[0];
    step[1]      = run[1] && (event_ext ? pin_fall : div_tick[1]);
    load[0]      = wr_sel.basic_count;
    load[1]      = wr_sel.event_count;
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_timer
      rate_divider u_div (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .clear (div_clear[i]),
        .rate  (rate[i]),
        .tick  (div_tick[i])
      );

      count_unit u_cnt (
        .clk        (ref_clk),
        .rst_n      (rst_n),
        .load       (load[i]),
        .load_value (req.wdata),
        .step       (step[i]),
        .count      (count[i]),
        .wrap       (wrap[i])
      );
    end
  endgenerate

  // ************************************************************
  // Interrupt status and enable
  // ************************************************************
  logic [2:0] irq_status_reg;
  logic [2:0] irq_status_next;
  logic [2:0] irq_enable_reg;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  always_comb begin
    irq_set                            = 3'h0;
    irq_set[timer_pkg::BASIC_IRQ_BIT]  = wrap[0];
    irq_set[timer_pkg::EVENT_IRQ_BIT]  = wrap[1];
    irq_set[timer_pkg::PIN_IRQ_BIT]    = pin_fall && !event_ext;
    irq_clr = wr_sel.irq_status ? req.wdata[2:0] : 3'h0;
    // A new event in the clearing cycle wins over the clear
    irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
    // Pin flag cannot rise while the pin feeds the event timer
    if (event_ext) begin
      irq_status_next[timer_pkg::PIN_IRQ_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= timer_pkg::IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_reg <= timer_pkg::IRQ_RESET;
    end else if (wr_sel.irq_enable) begin
      irq_enable_reg <= req.wdata[2:0];
    end
  end

  // Registered so the output is glitch free; lags the flag one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [7:0] rd_value;

  always_comb begin
    rd_value = 8'h00;
    if (rd_sel.basic_mode) begin
      rd_value = basic_mode_reg;
    end else if (rd_sel.basic_count) begin
      rd_value = count[0];
    end else if (rd_sel.event_mode) begin
      rd_value = event_mode_reg;
    end else if (rd_sel.event_count) begin
      rd_value = count[1];
    end else if (rd_sel.irq_status) begin
      rd_value = {5'h00, irq_status_reg};
    end else if (rd_sel.irq_enable) begin
      rd_value = {5'h00, irq_enable_reg};
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rd_value;
    end
  end

endmodule : dual_eight_bit_timers

// ==== test/dual_eight_bit_timers_asserts.sv ====
`timescale 1ns/100ps

module timers_chk (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic       event_input_pin,
  input wire logic       irq
);
  localparam logic [7:0] BM = timer_pkg::BASIC_MODE_OFS;
  localparam logic [7:0] BC = timer_pkg::BASIC_COUNT_OFS;
  localparam logic [7:0] EM = timer_pkg::EVENT_MODE_OFS;
  localparam logic [7:0] EN = timer_pkg::IRQ_ENABLE_OFS;
  logic [7:0] en_reg;
  logic       run_reg;

  // **********
  // Shadows of software writes, since internals are out of sight
  // **********
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_reg  <= 8'h00;
      run_reg <= 1'b0;
    end else if (bus_wr) begin
      if (bus_addr == EN) en_reg <= bus_wdata;
      if (bus_addr == BM) run_reg <= bus_wdata[7];
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Set-up order: load, enable the interrupt, then run
  sequence s_fast_arm;
    bus_wr && bus_addr == BC && bus_wdata == 8'hFF
    ##1 bus_wr && bus_addr == EN
    ##1 bus_wr && bus_addr == BM && bus_wdata == 8'hF0;
  endsequence

  sequence s_quiet;
    (!bus_wr)[*3] ##0 en_reg[0];
  endsequence

  a_rdata_idle: assert property (
    !bus_rd |=> bus_rdata == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (
    bus_rd && (bus_addr < BM || bus_addr > EN) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_basic_mode_rb: assert property (
    bus_wr && bus_addr == BM ##1 bus_rd && bus_addr == BM
    |=> bus_rdata == ($past(bus_wdata, 2) & 8'hF0))
    else $error("basic mode readback wrong");
  a_event_mode_rb: assert property (
    bus_wr && bus_addr == EM ##1 bus_rd && bus_addr == EM
    |=> bus_rdata == ($past(bus_wdata, 2) & 8'hF8))
    else $error("event mode readback wrong");
  a_count_replace: assert property (
    bus_wr && bus_addr == BC ##1 bus_rd && bus_addr == BC && !run_reg
    |=> bus_rdata == $past(bus_wdata, 2))
    else $error("count write not seen");
  a_irq_masked: assert property (
    (en_reg[2:0] == 3'h0)[*2] |-> !irq) else $error("masked irq seen");
  a_basic_wrap_irq: assert property (
    s_fast_arm ##1 s_quiet |=> irq) else $error("wrap irq late");
  a_irq_stays: assert property (
    (!bus_wr)[*2] ##0 irq |=> irq) else $error("irq dropped");
endmodule : timers_chk

bind dual_eight_bit_timers timers_chk i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .event_input_pin(event_input_pin), .irq(irq)
);

// ==== test/dual_eight_bit_timers_bench.sv ====
`timescale 1ns/100ps

module dual_eight_bit_timers_bench;
  localparam logic [7:0] BM = timer_pkg::BASIC_MODE_OFS;
  localparam logic [7:0] BC = timer_pkg::BASIC_COUNT_OFS;
  localparam logic [7:0] EM = timer_pkg::EVENT_MODE_OFS;
  localparam logic [7:0] EC = timer_pkg::EVENT_COUNT_OFS;
  localparam logic [7:0] ST = timer_pkg::IRQ_STATUS_OFS;
  localparam logic [7:0] EN = timer_pkg::IRQ_ENABLE_OFS;
  logic       ref_clk;
  logic       resetn;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic       event_input_pin;
  logic       irq;
  int         error_cnt;
  int         n_checks;
  int         cycles;
  int         div;
  logic [7:0] mo;
  logic [7:0] co;
  logic [7:0] bit_v;

  dual_eight_bit_timers i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .event_input_pin(event_input_pin), .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // **********
  // Checks, bus cycles and the closing report
  // **********
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_irq(input logic exp);
    #1;
    n_checks++;
    if (irq !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, irq, exp);
    end
  endtask : chk_irq

  // Leaves the strobe up: the next rd call or idle drops it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    bus_rd    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wr   <= 1'b0;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(negedge ref_clk);
    chk8(bus_rdata, exp);
  endtask : rd

  task automatic idle(input int n);
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    repeat (n - 1) @(posedge ref_clk);
  endtask : idle

  // Falling edges spaced wider than the pin sampler needs
  task automatic pulse(input int n);
    idle(1);
    repeat (n) begin
      event_input_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
      event_input_pin <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
  endtask : pulse

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  // **********
  // Test sequence
  // **********
  initial begin
    resetn          = 1'b0;
    bus_addr        = 8'h00;
    bus_wdata       = 8'h00;
    bus_wr          = 1'b0;
    bus_rd          = 1'b0;
    event_input_pin = 1'b1;
    error_cnt       = 0;
    n_checks        = 0;
    cycles          = 0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    idle(4);
    for (int a = 'hD8; a <= 'hDE; a++) begin
      rd(8'(a), 8'h00);
    end
    wr(BM, 8'h7F);
    rd(BM, 8'h70);
    wr(EM, 8'h7F);
    rd(EM, 8'h78);
    wr(BC, 8'hA5);
    rd(BC, 8'hA5);
    wr(EC, 8'h5A);
    rd(EC, 8'h5A);
    wr(BM, 8'h80);
    wr(BC, 8'h33);
    rd(BC, 8'h33);
    $display("test registers done");
    for (int t = 0; t < 2; t++) begin
      mo = t ? EM : BM;
      co = t ? EC : BC;
      for (int r = 0; r < 8; r++) begin
        div = 256 >> r;
        wr(mo, 8'h00);
        wr(co, 8'hFE);
        wr(mo, 8'h80 | 8'(r << 4));
        idle(3 * div + div / 2);
        rd(co, 8'h01);
      end
      wr(mo, 8'h70);
      wr(co, 8'hFE);
      idle(20);
      rd(co, 8'hFE);
    end
    $display("test prescale done");
    wr(ST, 8'h07);
    for (int t = 0; t < 2; t++) begin
      mo    = t ? EM : BM;
      co    = t ? EC : BC;
      bit_v = 8'h01 << t;
      wr(mo, 8'h00);
      wr(EN, 8'h00);
      wr(ST, bit_v);
      wr(mo, 8'h70);
      wr(co, 8'hFF);
      wr(EN, bit_v);
      wr(mo, 8'hF0);
      idle(2);
      chk_irq(1'b0);
      idle(4);
      chk_irq(1'b1);
      rd(ST, bit_v);
      wr(mo, 8'h00);
      wr(EN, 8'h00);
      idle(3);
      chk_irq(1'b0);
      rd(ST, bit_v);
      wr(ST, bit_v);
      rd(ST, 8'h00);
    end
    $display("test interrupt done");
    wr(EN, 8'h04);
    wr(EC, 8'h00);
    wr(EM, 8'h88);
    pulse(5);
    rd(EC, 8'h05);
    rd(ST, 8'h00);
    chk_irq(1'b0);
    wr(EM, 8'h08);
    pulse(2);
    rd(EC, 8'h05);
    wr(EM, 8'h00);
    pulse(1);
    rd(ST, 8'h04);
    chk_irq(1'b1);
    $display("test external done");
    conclude();
  end
endmodule : dual_eight_bit_timers_bench
